/* core/lsfs_consts.vh */
// Constants of the LED start-up and fault supervisor
`ifndef LSFS_CONSTS_VH
`define LSFS_CONSTS_VH
`define LSFS_CLK_HZ 25000000
`define LSFS_START_W 15
`define LSFS_START_FULL 15'h7FFF
`define LSFS_FCNT_W 9
`define LSFS_FCNT_FULL 9'h100
`define LSFS_PER_W 15
`define LSFS_PER_LAST 15'h7FFF
`define LSFS_HOLD_US 50
`define LSFS_HOLD_CYC ((`LSFS_HOLD_US * (`LSFS_CLK_HZ / 1000000)))
`define LSFS_HOLD_W 11
`define LSFS_HOLD_LAST 11'h4E1
`define LSFS_MODE_LLC 2'h0
`define LSFS_MODE_PWM 2'h1
`define LSFS_MODE_SYNC 2'h2
`define LSFS_ST_RESET 2'h0
`define LSFS_ST_SOFT 2'h1
`define LSFS_ST_RUN 2'h2
`define LSFS_ST_FAULT 2'h3
`endif

/* core/lsfs_hold.v */
// Retriggerable hold timer for one fault condition
`include "lsfs_consts.vh"
module lsfs_hold (
   clk,
   rst,
   cond,
   expire_clear
);
   input wire clk;
   input wire rst;
   input wire cond;
   output reg expire_clear;
   reg [`LSFS_HOLD_W-1:0] cnt_r;
   reg active_r;
   localparam [`LSFS_HOLD_W-1:0] HOLD_LAST = `LSFS_HOLD_LAST;
   // ====================================
   // Hold status, clear the counter when condition gone at expiry
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= {`LSFS_HOLD_W{1'b0}};
         active_r <= 1'b0;
         expire_clear <= 1'b0;
      end else begin
         expire_clear <= 1'b0;
         if (cond) begin
            active_r <= 1'b1;
            cnt_r <= {`LSFS_HOLD_W{1'b0}};
         end else if (active_r) begin
            if (cnt_r == HOLD_LAST) begin
               active_r <= 1'b0;
               expire_clear <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end
endmodule // lsfs_hold

/* core/lsfs_supervisor.v */
// Start-up sequencing and fault supervision of the LED drive controller
`include "lsfs_consts.vh"
module lsfs_supervisor (
   clk,
   rst,
   mode,
   current_sense_above_100mv,
   current_sense_above_600mv,
   current_sense_above_930mv,
   voltage_sense_above_2v,
   undervolt_sync_below_0p4v,
   integ_above_2p5v,
   pwm_a_in,
   pwm_b_in,
   aux_lead_in,
   aux_trail_in,
   phase_drive_a,
   phase_drive_b,
   aux_drive,
   softstart_active,
   brightness_compensation,
   comp_clamp,
   fault_n
);
   input wire clk;
   input wire rst;
   input wire [1:0] mode;
   input wire current_sense_above_100mv;
   input wire current_sense_above_600mv;
   input wire current_sense_above_930mv;
   input wire voltage_sense_above_2v;
   input wire undervolt_sync_below_0p4v;
   input wire integ_above_2p5v;
   input wire pwm_a_in;
   input wire pwm_b_in;
   input wire aux_lead_in;
   input wire aux_trail_in;
   output reg phase_drive_a;
   output reg phase_drive_b;
   output reg aux_drive;
   output reg softstart_active;
   output reg brightness_compensation;
   output reg comp_clamp;
   output reg fault_n;

   // ====================================
   // Input synchronizers, two flops per comparator
   reg [5:0] sync1_r;
   reg [5:0] sync2_r;
   // PWM inputs come from on-chip logic and are sampled directly
   wire [5:0] raw = {integ_above_2p5v, undervolt_sync_below_0p4v, voltage_sense_above_2v,
                     current_sense_above_930mv, current_sense_above_600mv, current_sense_above_100mv};
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate
   wire i100 = sync2_r[0];
   wire i600 = sync2_r[1];
   wire i930 = sync2_r[2];
   wire ov = sync2_r[3];
   wire uv = sync2_r[4];
   wire integ = sync2_r[5];

   // ====================================
   // State and counters
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`LSFS_START_W-1:0] start_r;
   reg start_done_r;
   reg seen_current_r;
   reg [`LSFS_FCNT_W-1:0] fcnt_r;
   reg [`LSFS_PER_W-1:0] per_r;
   reg out_of_reset_r;
   wire oc_clear;
   wire ov_clear;
   wire uv_clear;

   // ====================================
   // Hold timers for overcurrent, overvoltage and undervoltage; the open-string condition has none
   // Separate timers, so one expiry cannot cut another hold short
   lsfs_hold u_hold_oc (
      .clk(clk),
      .rst(rst),
      .cond(i600),
      .expire_clear(oc_clear)
   );
   lsfs_hold u_hold_ov (
      .clk(clk),
      .rst(rst),
      .cond(ov),
      .expire_clear(ov_clear)
   );
   lsfs_hold u_hold_uv (
      .clk(clk),
      .rst(rst),
      .cond(uv),
      .expire_clear(uv_clear)
   );

   // ====================================
   // Fault conditions
   wire leds_on = (state_r == `LSFS_ST_RUN) && integ;
   wire open_fault = start_done_r && leds_on && !i100;
   wire count_cond = open_fault || i600 || ov || uv;
   wire per_wrap = (per_r == `LSFS_PER_LAST);
   // Hold expiry clears when its own condition is gone, even if another condition is still counting
   wire hold_clear = (oc_clear && !i600) || (ov_clear && !ov) || (uv_clear && !uv);
   // Current above 100mV clears open-string count but not an active overcurrent count
   wire good_clear = start_done_r && i100 && !i600 && !ov && !uv;
   wire start_fail = (start_r == `LSFS_START_FULL) && !start_done_r && !seen_current_r;
   wire count_fault = (fcnt_r == `LSFS_FCNT_FULL);
   wire short_fault = i930 && out_of_reset_r;

   // ====================================
   // Next-state logic
   // Fault wins over every other transition, so a trip is never lost
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `LSFS_ST_RESET: state_nxt = `LSFS_ST_SOFT;
         `LSFS_ST_SOFT: if (integ) state_nxt = `LSFS_ST_RUN;
         `LSFS_ST_RUN: state_nxt = `LSFS_ST_RUN;
         `LSFS_ST_FAULT: state_nxt = `LSFS_ST_FAULT;
         default: state_nxt = `LSFS_ST_RESET;
      endcase
      if (short_fault || start_fail || count_fault) begin
         state_nxt = `LSFS_ST_FAULT;
      end
   end

   // ====================================
   // Start timer, period counter and fault counter
   // Clear wins over count, so a restart always begins from zero
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= `LSFS_ST_RESET;
         start_r <= {`LSFS_START_W{1'b0}};
         start_done_r <= 1'b0;
         seen_current_r <= 1'b0;
         fcnt_r <= {`LSFS_FCNT_W{1'b0}};
         per_r <= {`LSFS_PER_W{1'b0}};
         out_of_reset_r <= 1'b0;
      end else begin
         out_of_reset_r <= 1'b1;
         state_r <= state_nxt;
         if (i100) begin
            seen_current_r <= 1'b1;
         end
         if (!start_done_r) begin
            if (start_r == `LSFS_START_FULL) begin
               start_done_r <= 1'b1;
            end else begin
               start_r <= start_r + 1'b1;
            end
         end
         per_r <= per_r + 1'b1;
         if (state_r == `LSFS_ST_FAULT) begin
            fcnt_r <= fcnt_r;
         end else if (per_wrap || hold_clear || good_clear) begin
            fcnt_r <= {`LSFS_FCNT_W{1'b0}};
         end else if (count_cond && !count_fault) begin
            fcnt_r <= fcnt_r + 1'b1;
         end
      end
   end

   // ====================================
   // Registered outputs
   // Gated by the next state too, so drives drop in the cycle the fault flag falls
   wire drive_en = (state_r == `LSFS_ST_RUN) && integ && !i930;
   wire fault_next = (state_nxt == `LSFS_ST_FAULT);
   wire drive_ok = drive_en && !short_fault && !fault_next;
   wire aux_sel = (mode == `LSFS_MODE_PWM) ? aux_trail_in : aux_lead_in;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_drive_a <= 1'b0;
         phase_drive_b <= 1'b0;
         aux_drive <= 1'b0;
         softstart_active <= 1'b0;
         brightness_compensation <= 1'b0;
         comp_clamp <= 1'b0;
         fault_n <= 1'b1;
      end else begin
         phase_drive_a <= drive_ok && pwm_a_in;
         phase_drive_b <= drive_ok && pwm_b_in;
         aux_drive <= drive_ok && aux_sel;
         softstart_active <= (state_nxt == `LSFS_ST_SOFT);
         brightness_compensation <= (state_nxt == `LSFS_ST_RUN);
         comp_clamp <= ov && (state_nxt != `LSFS_ST_FAULT);
         fault_n <= (state_nxt != `LSFS_ST_FAULT);
      end
   end
endmodule // lsfs_supervisor

/* bench/lsfs_power_stage.sv */
// Behavioural LED power stage around the supervisor
module lsfs_power_stage (
   input wire logic clk,
   input wire logic rst,
   input wire logic phase_drive_a,
   input wire logic phase_drive_b,
   input wire logic open_string,
   output logic current_sense_above_100mv,
   output logic integ_above_2p5v
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ramp_r;
   // ======
   // Model
   // Slow integrator charge, so soft start lasts 202 cycles
   always @(posedge clk or posedge rst) begin
      if (rst) ramp_r <= 8'h00;
      else if (!integ_above_2p5v) ramp_r <= ramp_r + 8'h01;
   end
   assign integ_above_2p5v = ramp_r == 8'hC8;
   // A broken string carries no current even while driven
   assign current_sense_above_100mv = (phase_drive_a | phase_drive_b) & !open_string;
endmodule // lsfs_power_stage

/* bench/lsfs_supervisor_assertions.sv */
// Checker of the LED start-up and fault supervisor
`include "lsfs_consts.vh"
module lsfs_supervisor_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] mode,
   input wire logic current_sense_above_930mv,
   input wire logic voltage_sense_above_2v,
   input wire logic integ_above_2p5v,
   input wire logic aux_lead_in,
   input wire logic aux_trail_in,
   input wire logic phase_drive_a,
   input wire logic phase_drive_b,
   input wire logic aux_drive,
   input wire logic softstart_active,
   input wire logic comp_clamp,
   input wire logic fault_n
);
   timeunit 1ns;
   timeprecision 1ns;
   wire drv = phase_drive_a | phase_drive_b | aux_drive;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ======
   // Checks
   a_fault_latch: assert property (!fault_n |=> !fault_n) else $error("fault released");
   a_fault_quiet: assert property (!fault_n |-> !drv) else $error("drive in fault");
   a_short_trip: assert property (current_sense_above_930mv |-> ##[1:4] !fault_n) else $error("short missed");
   a_soft_gate: assert property (drv |-> !softstart_active) else $error("drive in soft start");
   a_integ_gate: assert property (!integ_above_2p5v [*4] |=> !drv) else $error("drive, integ low");
   a_aux_trail: assert property (aux_drive && $past(mode) == `LSFS_MODE_PWM |-> $past(aux_trail_in))
      else $error("aux trail");
   a_aux_lead: assert property (aux_drive && $past(mode) != `LSFS_MODE_PWM |-> $past(aux_lead_in))
      else $error("aux lead");
   a_ov_clamp: assert property (voltage_sense_above_2v [*3] |=> comp_clamp || !fault_n) else $error("no clamp");
   c_fault: cover property (!fault_n);
   c_clamp: cover property (comp_clamp);
   c_aux: cover property (aux_drive);
endmodule // lsfs_supervisor_chk
bind lsfs_supervisor lsfs_supervisor_chk lsfs_supervisor_chk_inst (.*);

/* bench/lsfs_supervisor_tb.sv */
// Testbench of the LED start-up and fault supervisor
`include "lsfs_consts.vh"
module lsfs_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst, current_sense_above_930mv = 1'b0, voltage_sense_above_2v = 1'b0, open_string = 1'b0;
   logic current_sense_above_600mv = 1'b0, undervolt_sync_below_0p4v = 1'b0, pwm_a_in = 1'b1, pwm_b_in = 1'b0;
   logic aux_lead_in = 1'b1, aux_trail_in = 1'b0, current_sense_above_100mv, integ_above_2p5v;
   logic [1:0] mode = `LSFS_MODE_LLC;
   logic phase_drive_a, phase_drive_b, aux_drive, softstart_active, brightness_compensation, comp_clamp, fault_n;
   wire [2:0] drv = {phase_drive_a, phase_drive_b, aux_drive};
   int error_cnt = 0, n_checks = 0;
   always #20 clk = ~clk;
   lsfs_power_stage lsfs_power_stage_inst (.*);
   lsfs_supervisor lsfs_supervisor_inst (.*);
   // ======
   // Helpers
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic restart(input int settle);
      rst = 1'b1;
      cyc(20);
      rst = 1'b0;
      cyc(settle);
   endtask
   // Bounded so a missing fault cannot hang the run
   task automatic wait_fault(input int lim);
      for (int k = 0; fault_n !== 1'b0; k++) begin
         if (k == lim) begin
            error_cnt++;
            complete_run;
         end
         cyc(1);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ======
   // Scenarios
   task automatic test_run;
      restart(220);
      check({softstart_active, brightness_compensation, fault_n}, 3'h3);
      check(drv, 3'h5);
      mode = `LSFS_MODE_PWM;
      cyc(2);
      check(drv, 3'h4);
      {pwm_a_in, pwm_b_in, aux_trail_in} = 3'h3;
      cyc(2);
      check(drv, 3'h3);
      {mode, aux_lead_in} = {`LSFS_MODE_SYNC, 1'b0};
      cyc(2);
      check(drv, 3'h2);
      $display("run test done");
   endtask
   task automatic test_short;
      restart(5);
      check({2'h0, softstart_active}, 3'h1);
      current_sense_above_930mv = 1'b1;
      cyc(1);
      current_sense_above_930mv = 1'b0;
      wait_fault(5);
      cyc(300);
      check({fault_n, phase_drive_a, phase_drive_b}, 3'h0);
      $display("short test done");
   endtask
   // Open string keeps good current from clearing, so only the hold can
   task automatic test_ov;
      restart(220);
      open_string = 1'b1;
      voltage_sense_above_2v = 1'b1;
      cyc(100);
      voltage_sense_above_2v = 1'b0;
      cyc(1300);
      voltage_sense_above_2v = 1'b1;
      cyc(200);
      check({1'b0, comp_clamp, fault_n}, 3'h3);
      wait_fault(120);
      check({1'b0, comp_clamp, fault_n}, 3'h0);
      voltage_sense_above_2v = 1'b0;
      open_string = 1'b0;
      $display("ov test done");
   endtask
   // Without the hold clear, 300 counted cycles would trip the fault early
   task automatic test_oc;
      restart(220);
      current_sense_above_600mv = 1'b1;
      cyc(100);
      current_sense_above_600mv = 1'b0;
      cyc(1300);
      current_sense_above_600mv = 1'b1;
      cyc(200);
      check({2'h0, fault_n}, 3'h1);
      wait_fault(120);
      current_sense_above_600mv = 1'b0;
      $display("oc test done");
   endtask
   task automatic test_uv;
      restart(220);
      undervolt_sync_below_0p4v = 1'b1;
      cyc(100);
      undervolt_sync_below_0p4v = 1'b0;
      cyc(1300);
      undervolt_sync_below_0p4v = 1'b1;
      cyc(200);
      check({2'h0, fault_n}, 3'h1);
      wait_fault(120);
      undervolt_sync_below_0p4v = 1'b0;
      $display("uv test done");
   endtask
   task automatic test_start;
      open_string = 1'b1;
      restart(32700);
      check({2'h0, fault_n}, 3'h1);
      wait_fault(150);
      open_string = 1'b0;
      restart(32900);
      check({2'h0, fault_n}, 3'h1);
      open_string = 1'b1;
      cyc(200);
      check({2'h0, fault_n}, 3'h1);
      open_string = 1'b0;
      cyc(1);
      open_string = 1'b1;
      cyc(240);
      check({2'h0, fault_n}, 3'h1);
      wait_fault(30);
      $display("start test done");
   endtask
   initial begin
      test_run;
      test_short;
      test_ov;
      test_oc;
      test_uv;
      test_start;
      complete_run;
   end
endmodule // lsfs_supervisor_tb
